// >>> logic/sepc_buf2.v
// Two-entry valid/ready buffer between cache drain and array port
`timescale 1ns/1ps
`default_nettype none
module sepc_buf2 #(
  parameter W = 21
) (
  input  wire         clk,       // System clock
  input  wire         rst_n,     // Synchronised reset, active low
  input  wire         in_valid,  // Word offered
  output wire         in_ready,  // Room for a word
  input  wire [W-1:0] in_data,   // Word in
  output wire         out_valid, // Word held
  input  wire         out_ready, // Receiver takes it
  output wire [W-1:0] out_data,  // Word out
  output wire         empty      // Nothing held
);
  reg [W-1:0] ent0_r;
  reg [W-1:0] ent1_r;
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;

  // Full at two, so the drain stalls instead of losing words
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign empty     = (cnt_r == 2'h0);
  assign out_data  = rp_r ? ent1_r : ent0_r;

  // Storage and pointers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ent0_r <= {W{1'b0}};
      ent1_r <= {W{1'b0}};
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      cnt_r  <= 2'h0;
    end else begin
      if (push && !wp_r) ent0_r <= in_data;
      if (push && wp_r) ent1_r <= in_data;
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> logic/sepc_defines.vh
// Constants shared by the serial memory protect and cache block
// Functional notes
// - Config byte bit 7 clear programs high-endurance block from upper address bits.
// - After protection is set, relocating the high-endurance block is ignored.
// - Unprogrammed high-endurance location defaults to the highest block.
// - Protect a contiguous region of 0 to 15 blocks: start block plus count.
// - Block count zero leaves the whole array writable.
// - Factory settings: start block 15, block count zero.
// - Protection settings accepted once; later changes rejected.
// - Protect command: address byte bit 7 set, start in bits 1-4, others ignored.
// - Second byte is a filler, ignored but acknowledged.
// - Third byte: bit 7 high, bit 6 low, count in bits 0-3; STOP completes.
// - Writes to protected locations are dropped silently, no abort.
// - Writes crossing the protect boundary keep only unprotected bytes.
// - Config byte with bit 6 set is a readback returning two bytes.
// - Readback bytes: upper nibble ones; first start block, second count.
// - No control-byte ack during an internal write cycle; normal afterwards.
// - Write data loads a 64-byte cache of 8 pages until STOP.
// - One page cycle of at most 5 ms per loaded page, partial pages too; the code waits a full 5 ms after draining each page's bytes.
// - Beyond 64 bytes the load pointer wraps to cache page 0.
// - Cached pages go to sequential array pages across block boundaries.
// - STOP ending a write starts the self-timed cycle; no acks meanwhile.
`ifndef SEPC_DEFINES_VH
`define SEPC_DEFINES_VH

// ==========================================================
// Command byte fields
`define SEPC_SEL_BIT      7
`define SEPC_RB_BIT       6
`define SEPC_BLK_HI       4
`define SEPC_BLK_LO       1
`define SEPC_BYTE_BITS    4'h8
`define SEPC_TX_LAST      4'h7
`define SEPC_IDX_HI       2'h1
`define SEPC_IDX_LO       2'h2
`define SEPC_IDX_DATA     2'h3

// ==========================================================
// Reset and default values
`define SEPC_FACT_START   4'hf
`define SEPC_FACT_COUNT   4'h0
`define SEPC_TOP_BLOCK    4'hf
`define SEPC_RB_FILL      4'hf
`define SEPC_LAST_PAGE    3'h7
`define SEPC_LAST_BYTE    3'h7

// ==========================================================
// Timing
`define SEPC_PAGE_TIME_US 5000
`define SEPC_CLK_MHZ      100
`define SEPC_PAGE_CYC     (`SEPC_PAGE_TIME_US * `SEPC_CLK_MHZ)

`endif

// >>> logic/sepc_sync.v
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sepc_sync #(
  parameter W = 5
) (
  input  wire         clk,   // System clock
  input  wire         rst_n, // Synchronised reset, active low
  input  wire [W-1:0] d,     // Asynchronous inputs
  output wire [W-1:0] q      // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule
`default_nettype wire

// >>> logic/sepc_top.v
// Two-wire memory slave: protection, high-endurance block and write cache
`timescale 1ns/1ps
`default_nettype none
`include "sepc_defines.vh"
module sepc_top #(
  parameter [3:0]  DEV_CODE = 4'h5,          // Device type code, value arbitrary
  parameter [19:0] PAGE_CYC = `SEPC_PAGE_CYC // Cycles per page write cycle
) (
  input  wire        mclk,                 // 100 MHz clock
  input  wire        rstn,                 // Async reset, active low
  input  wire        scl,                  // Bus clock pin
  input  wire        sda_in,               // Bus data pin level
  output wire        sda_out,              // Bus data drive value, always low
  output wire        sda_oe_n,             // Low while pulling data low
  input  wire        chip_select_bit_low,  // Select strap, bit 0
  input  wire        chip_select_bit_mid,  // Select strap, bit 1
  input  wire        chip_select_bit_high, // Select strap, bit 2
  output wire [12:0] arr_rd_addr,          // Array read address
  input  wire [7:0]  arr_rd_data,          // Array read data
  output wire        arr_wr_valid,         // Array byte write request
  input  wire        arr_wr_ready,         // Array accepts the byte
  output wire [12:0] arr_wr_addr,          // Array write address
  output wire [7:0]  arr_wr_data,          // Array write data
  input  wire [3:0]  nv_prot_start,        // Stored start block
  input  wire [3:0]  nv_prot_count,        // Stored block count
  input  wire        nv_locked,            // Stored protect-set flag
  input  wire [3:0]  nv_he_block,          // Stored high-endurance block
  input  wire        nv_he_set,            // Stored high-endurance-set flag
  output wire        nv_save,              // Pulse: store cfg outputs
  output wire [3:0]  cfg_prot_start,       // Protect start block
  output wire [3:0]  cfg_prot_count,       // Protect block count
  output wire        cfg_locked,           // Protection programmed
  output wire [3:0]  cfg_he_block,         // Effective high-endurance block
  output wire        cfg_he_set,           // High-endurance block programmed
  output wire        busy                  // Internal write cycle running
);
  // ==========================================================
  // Reset release and pin synchronisers
  reg  [1:0] rs_r;
  wire       rst_n = rs_r[1];
  wire [4:0] pin_s;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) rs_r <= 2'h0;
    else rs_r <= {rs_r[0], 1'b1};
  end

  sepc_sync #(.W(5)) u_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({scl, sda_in, chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low}),
    .q     (pin_s)
  );

  wire       scl_s = pin_s[4];
  wire       sda_s = pin_s[3];
  wire [2:0] cs_s  = pin_s[2:0];
  reg        scl_q_r;
  reg        sda_q_r;
  wire scl_rise = scl_s && !scl_q_r;
  wire scl_fall = !scl_s && scl_q_r;
  wire start_c  = scl_s && scl_q_r && sda_q_r && !sda_s;
  wire stop_c   = scl_s && scl_q_r && !sda_q_r && sda_s;

  // ==========================================================
  // Serial engine state
  localparam [2:0] SI_IDLE = 3'h0;
  localparam [2:0] SI_RX   = 3'h1;
  localparam [2:0] SI_ACK  = 3'h2;
  localparam [2:0] SI_TX   = 3'h3;
  localparam [2:0] SI_MACK = 3'h4;
  localparam [1:0] OP_NONE = 2'h0;
  localparam [1:0] OP_PROT = 2'h1;
  localparam [1:0] OP_HE   = 2'h2;

  reg [2:0]  st_r;
  reg [3:0]  bcnt_r;
  reg [7:0]  sh_r;
  reg [1:0]  idx_r;
  reg        oe_n_r;
  reg        rd_r;
  reg        cfg_r;
  reg        mack_r;
  reg [7:0]  ahi_r;
  reg [12:0] addr_r;
  reg [12:0] base_r;
  reg [5:0]  wptr_r;
  reg [63:0] valid_r;
  reg        wr_any_r;
  reg [1:0]  cfg_op_r;
  reg [3:0]  pstart_r;
  reg [3:0]  pcount_r;
  reg        rb_pend_r;
  reg        rb_idx_r;
  reg [3:0]  prot_start_r;
  reg [3:0]  prot_count_r;
  reg        locked_r;
  reg [3:0]  he_r;
  reg        he_set_r;
  reg        ld_pend_r;
  reg        nv_save_r;
  reg [7:0]  cache_r [0:63];

  // Drain state, declared here for the busy gate
  localparam [1:0] DR_IDLE = 2'h0;
  localparam [1:0] DR_BYTE = 2'h1;
  localparam [1:0] DR_WAIT = 2'h2;
  reg [1:0]  dr_st_r;
  reg [2:0]  pg_r;
  reg [2:0]  by_r;
  reg [19:0] tmr_r;

  assign busy = (dr_st_r != DR_IDLE);

  wire byte_done = (st_r == SI_RX) && scl_fall && (bcnt_r == `SEPC_BYTE_BITS)
                   && !start_c && !stop_c;
  wire cache_we  = byte_done && (idx_r == `SEPC_IDX_DATA) && !cfg_r;
  wire addr_ok   = (sh_r[7:4] == DEV_CODE) && (sh_r[3:1] == cs_s);
  wire wr_go     = stop_c && wr_any_r;
  wire cfg_go    = stop_c && (cfg_op_r != OP_NONE) && !locked_r && !busy;

  // Readback bytes carry ones in the upper nibble
  wire [7:0] tx_byte = !rb_pend_r ? arr_rd_data :
                       rb_idx_r   ? {`SEPC_RB_FILL, prot_count_r} :
                                    {`SEPC_RB_FILL, prot_start_r};

  // Protected when count is non-zero and block falls in [start, start+count)
  function is_prot;
    input [3:0] blk;
    input [3:0] first;
    input [3:0] cnt;
    reg   [4:0] lim;
    begin
      lim     = {1'b0, first} + {1'b0, cnt};
      is_prot = (cnt != 4'h0) && (blk >= first) && ({1'b0, blk} < lim);
    end
  endfunction

  // Cache storage holds data only, so it needs no reset
  always @(posedge mclk) begin
    if (cache_we) cache_r[wptr_r] <= sh_r;
  end

  // ==========================================================
  // Serial engine: framing, acks, command decode, settings
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r      <= 1'b1;
      sda_q_r      <= 1'b1;
      st_r         <= SI_IDLE;
      bcnt_r       <= 4'h0;
      sh_r         <= 8'h00;
      idx_r        <= 2'h0;
      oe_n_r       <= 1'b1;
      rd_r         <= 1'b0;
      cfg_r        <= 1'b0;
      mack_r       <= 1'b0;
      ahi_r        <= 8'h00;
      addr_r       <= 13'h0000;
      base_r       <= 13'h0000;
      wptr_r       <= 6'h00;
      valid_r      <= 64'h0;
      wr_any_r     <= 1'b0;
      cfg_op_r     <= OP_NONE;
      pstart_r     <= 4'h0;
      pcount_r     <= 4'h0;
      rb_pend_r    <= 1'b0;
      rb_idx_r     <= 1'b0;
      prot_start_r <= `SEPC_FACT_START;
      prot_count_r <= `SEPC_FACT_COUNT;
      locked_r     <= 1'b0;
      he_r         <= `SEPC_TOP_BLOCK;
      he_set_r     <= 1'b0;
      ld_pend_r    <= 1'b1;
      nv_save_r    <= 1'b0;
    end else begin
      scl_q_r   <= scl_s;
      sda_q_r   <= sda_s;
      nv_save_r <= 1'b0;
      // Settings come back from nonvolatile storage once after reset
      if (ld_pend_r) begin
        ld_pend_r    <= 1'b0;
        prot_start_r <= nv_prot_start;
        prot_count_r <= nv_prot_count;
        locked_r     <= nv_locked;
        he_r         <= nv_he_block;
        he_set_r     <= nv_he_set;
      end
      if (start_c) begin
        st_r   <= SI_RX;
        bcnt_r <= 4'h0;
        idx_r  <= 2'h0;
        oe_n_r <= 1'b1;
      end else if (stop_c) begin
        st_r      <= SI_IDLE;
        oe_n_r    <= 1'b1;
        rb_pend_r <= 1'b0;
        wr_any_r  <= 1'b0;
        cfg_op_r  <= OP_NONE;
        // Settings commit at STOP, only while unlocked
        if (cfg_go && (cfg_op_r == OP_PROT)) begin
          prot_start_r <= pstart_r;
          prot_count_r <= pcount_r;
          locked_r     <= 1'b1;
          nv_save_r    <= 1'b1;
        end
        if (cfg_go && (cfg_op_r == OP_HE)) begin
          he_r      <= ahi_r[`SEPC_BLK_HI:`SEPC_BLK_LO];
          he_set_r  <= 1'b1;
          nv_save_r <= 1'b1;
        end
      end else begin
        case (st_r)
          SI_RX: begin
            if (scl_rise && (bcnt_r != `SEPC_BYTE_BITS)) begin
              sh_r   <= {sh_r[6:0], sda_s};
              bcnt_r <= bcnt_r + 4'h1;
            end else if (byte_done) begin
              bcnt_r <= 4'h0;
              if (idx_r != `SEPC_IDX_DATA) idx_r <= idx_r + 2'h1;
              st_r   <= SI_ACK;
              oe_n_r <= 1'b0;
              if (idx_r == 2'h0) begin
                // Busy or foreign code: stay silent until next START
                if (!addr_ok || busy) begin
                  st_r   <= SI_IDLE;
                  oe_n_r <= 1'b1;
                end
                rd_r <= sh_r[0];
              end else if (idx_r == `SEPC_IDX_HI) begin
                ahi_r <= sh_r;
                cfg_r <= sh_r[`SEPC_SEL_BIT];
              end else if (idx_r == `SEPC_IDX_LO) begin
                // In config mode this byte is the ignored filler
                if (!cfg_r) begin
                  addr_r  <= {ahi_r[4:0], sh_r};
                  base_r  <= {ahi_r[4:0], sh_r};
                  wptr_r  <= {3'h0, sh_r[2:0]};
                  valid_r <= 64'h0;
                end
              end else if (cfg_r) begin
                if (idx_r != bcnt_r[1:0] && cfg_op_r == OP_NONE && !rb_pend_r) begin
                  if (!sh_r[`SEPC_SEL_BIT]) begin
                    cfg_op_r <= OP_HE;
                  end else if (sh_r[`SEPC_RB_BIT]) begin
                    rb_pend_r <= 1'b1;
                    rb_idx_r  <= 1'b0;
                  end else begin
                    cfg_op_r <= OP_PROT;
                    pstart_r <= ahi_r[`SEPC_BLK_HI:`SEPC_BLK_LO];
                    pcount_r <= sh_r[3:0];
                  end
                end
              end else begin
                // Pointer wraps inside 64 bytes, overwriting page 0 first
                valid_r[wptr_r] <= 1'b1;
                wptr_r   <= wptr_r + 6'h01;
                addr_r   <= {addr_r[12:6], addr_r[5:0] + 6'h01};
                wr_any_r <= 1'b1;
              end
            end
          end
          SI_ACK: begin
            if (scl_fall) begin
              bcnt_r <= 4'h0;
              if (rd_r) begin
                st_r   <= SI_TX;
                sh_r   <= tx_byte;
                oe_n_r <= tx_byte[7];
              end else begin
                st_r   <= SI_RX;
                oe_n_r <= 1'b1;
              end
            end
          end
          SI_TX: begin
            if (scl_fall) begin
              if (bcnt_r == `SEPC_TX_LAST) begin
                st_r   <= SI_MACK;
                oe_n_r <= 1'b1;
                bcnt_r <= 4'h0;
              end else begin
                sh_r   <= {sh_r[6:0], 1'b0};
                oe_n_r <= sh_r[6];
                bcnt_r <= bcnt_r + 4'h1;
              end
            end
          end
          SI_MACK: begin
            if (scl_rise) begin
              mack_r <= !sda_s;
              if (rb_pend_r) rb_idx_r <= 1'b1;
              else addr_r <= addr_r + 13'h0001;
            end else if (scl_fall) begin
              if (mack_r) begin
                st_r   <= SI_TX;
                sh_r   <= tx_byte;
                oe_n_r <= tx_byte[7];
              end else begin
                st_r <= SI_IDLE;
              end
            end
          end
          default: begin
            st_r <= SI_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Cache drain: one timed cycle per loaded page
  wire [5:0]  cidx     = {pg_r, by_r};
  wire [9:0]  dst_page = base_r[12:3] + {7'h00, pg_r};
  wire [12:0] dst_addr = {dst_page, by_r};
  wire        prot_hit = is_prot(dst_addr[12:9], prot_start_r, prot_count_r);
  wire        page_any = |valid_r[{pg_r, 3'h0} +: 8];
  wire        buf_rdy;
  wire        buf_empty;
  wire        buf_push = (dr_st_r == DR_BYTE) && valid_r[cidx] && !prot_hit;

  // Stalls on a full buffer rather than dropping a byte
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dr_st_r <= DR_IDLE;
      pg_r    <= 3'h0;
      by_r    <= 3'h0;
      tmr_r   <= 20'h0;
    end else begin
      case (dr_st_r)
        DR_IDLE: begin
          if (wr_go) begin
            dr_st_r <= DR_BYTE;
            pg_r    <= 3'h0;
            by_r    <= 3'h0;
          end else if (cfg_go) begin
            dr_st_r <= DR_WAIT;
            pg_r    <= `SEPC_LAST_PAGE;
            tmr_r   <= 20'h0;
          end
        end
        DR_BYTE: begin
          if ((by_r == 3'h0) && !page_any) begin
            if (pg_r == `SEPC_LAST_PAGE) dr_st_r <= DR_IDLE;
            else pg_r <= pg_r + 3'h1;
          end else if (!valid_r[cidx] || prot_hit || buf_rdy) begin
            by_r <= by_r + 3'h1;
            if (by_r == `SEPC_LAST_BYTE) begin
              dr_st_r <= DR_WAIT;
              tmr_r   <= 20'h0;
            end
          end
        end
        DR_WAIT: begin
          // Full page time even for a partial page
          if (tmr_r != PAGE_CYC - 20'h1) begin
            tmr_r <= tmr_r + 20'h1;
          end else if (buf_empty) begin
            if (pg_r == `SEPC_LAST_PAGE) dr_st_r <= DR_IDLE;
            else begin
              pg_r    <= pg_r + 3'h1;
              dr_st_r <= DR_BYTE;
            end
          end
        end
        default: begin
          dr_st_r <= DR_IDLE;
        end
      endcase
    end
  end

  sepc_buf2 #(.W(21)) u_buf (
    .clk       (mclk),
    .rst_n     (rst_n),
    .in_valid  (buf_push),
    .in_ready  (buf_rdy),
    .in_data   ({dst_addr, cache_r[cidx]}),
    .out_valid (arr_wr_valid),
    .out_ready (arr_wr_ready),
    .out_data  ({arr_wr_addr, arr_wr_data}),
    .empty     (buf_empty)
  );

  // ==========================================================
  // Outputs
  assign sda_out        = 1'b0;
  assign sda_oe_n       = oe_n_r;
  assign arr_rd_addr    = addr_r;
  assign nv_save        = nv_save_r;
  assign cfg_prot_start = prot_start_r;
  assign cfg_prot_count = prot_count_r;
  assign cfg_locked     = locked_r;
  assign cfg_he_block   = he_set_r ? he_r : `SEPC_TOP_BLOCK;
  assign cfg_he_set     = he_set_r;
endmodule
`default_nettype wire

// >>> sim/sepc_chk_assertions.sv
// Port-level checks for the protect and cache block
`timescale 1ns/1ps
`default_nettype none
module sepc_chk #(
  parameter [19:0] PAGE_CYC = 20'h000c8 // Cycles per page
) (
  input wire logic        mclk,           // Clock
  input wire logic        rstn,           // Reset, active low
  input wire logic        sda_oe_n,       // Data pull, low drives
  input wire logic        arr_wr_valid,   // Array write request
  input wire logic        arr_wr_ready,   // Array accepts
  input wire logic [12:0] arr_wr_addr,    // Write address
  input wire logic [7:0]  arr_wr_data,    // Write data
  input wire logic        nv_save,        // Store pulse
  input wire logic [3:0]  cfg_prot_start, // Start block
  input wire logic [3:0]  cfg_prot_count, // Block count
  input wire logic        cfg_locked,     // Protect set
  input wire logic [3:0]  cfg_he_block,   // Endurance block
  input wire logic        cfg_he_set,     // Endurance set
  input wire logic        busy            // Write cycle
);
  // ====================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic [31:0] bcnt_r;
  // Busy length counter; a partial page still costs a whole page time
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) bcnt_r <= 32'h0;
    else bcnt_r <= busy ? bcnt_r + 32'h1 : 32'h0;
  sequence s_held;
    arr_wr_valid && $stable(arr_wr_addr) && $stable(arr_wr_data);
  endsequence
  a_busy_len: assert property ($fell(busy) |-> bcnt_r >= PAGE_CYC)
    else $error("write cycle shorter than a page time");
  a_no_ack_busy: assert property (busy |-> sda_oe_n)
    else $error("data pulled low during write cycle");
  a_wr_in_cycle: assert property (arr_wr_valid |-> busy)
    else $error("array write outside write cycle");
  a_wr_held: assert property (arr_wr_valid && !arr_wr_ready |=> s_held)
    else $error("array word dropped while stalled");
  a_save_once: assert property (cfg_locked && $past(cfg_locked, 3) |-> !nv_save)
    else $error("settings saved after lock");
  a_prot_frozen: assert property ($past(cfg_locked, 2) |->
    $stable({cfg_prot_start, cfg_prot_count}))
    else $error("protect settings changed after lock");
  a_he_frozen: assert property ($past(cfg_locked, 2) |-> $stable(cfg_he_block))
    else $error("endurance block moved after lock");
  a_he_default: assert property (!cfg_he_set |-> cfg_he_block == 4'hf)
    else $error("endurance block not at top by default");
endmodule
bind sepc_top sepc_chk #(.PAGE_CYC(PAGE_CYC)) u_chk (.mclk, .rstn, .sda_oe_n, .arr_wr_valid,
  .arr_wr_ready, .arr_wr_addr, .arr_wr_data, .nv_save, .cfg_prot_start, .cfg_prot_count,
  .cfg_locked, .cfg_he_block, .cfg_he_set, .busy);
`default_nettype wire

// >>> sim/sepc_master.sv
// Two-wire bus master model, 125 ns bit time
`timescale 1ns/1ps
`default_nettype none
module sepc_master (
  output var logic scl,   // Bus clock, idle high
  output var logic sda_m, // Data drive, 1 releases
  input wire logic line   // Resolved data wire
);
  // ====================
  // Bus actions; clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Data moves only while the clock is low
  task automatic bitx(input logic v, output logic r);
    sda_m = v;
    #31.25 scl = 1'b1;
    #31.25 r = line;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b1;
    #125;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(output logic [7:0] v, input logic mack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(~mack, r);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the protect and cache block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam [3:0]  DEV = 4'h6;      // Device code, value arbitrary
  localparam [19:0] PC  = 20'h000c8; // Shortened page time
  logic mclk = 1'b0, rstn = 1'b0, arr_wr_ready = 1'b0, sv_r = 1'b0, a;
  logic [2:0] cs = 3'h0;
  logic [3:0] nv_prot_start = 4'hf, nv_prot_count = 4'h0, nv_he_block = 4'h2;
  logic [3:0] pst = 4'hf, pcn = 4'h0;
  logic nv_locked = 1'b0, nv_he_set = 1'b0;
  logic [7:0] d [0:79], b;
  logic [20:0] wq [$], eq [$];
  integer seed = 10, fail_count = 0, comparisons = 0, bc = 0, x;
  wire scl, sda_m, sda_out, sda_oe_n, arr_wr_valid, nv_save, cfg_locked, cfg_he_set, busy;
  wire [12:0] arr_rd_addr, arr_wr_addr;
  wire [7:0]  arr_wr_data;
  wire [3:0]  cfg_prot_start, cfg_prot_count, cfg_he_block;
  wire        sda_in = sda_m & (sda_oe_n | sda_out);
  wire [7:0]  arr_rd_data = ~arr_rd_addr[7:0];
  always #5 mclk = ~mclk;
  sepc_master m (.scl, .sda_m, .line(sda_in));
  sepc_top #(.DEV_CODE(DEV), .PAGE_CYC(PC)) uut (.mclk, .rstn, .scl, .sda_in, .sda_out,
    .sda_oe_n, .chip_select_bit_low(cs[0]), .chip_select_bit_mid(cs[1]),
    .chip_select_bit_high(cs[2]), .arr_rd_addr, .arr_rd_data, .arr_wr_valid, .arr_wr_ready,
    .arr_wr_addr, .arr_wr_data, .nv_prot_start, .nv_prot_count, .nv_locked, .nv_he_block,
    .nv_he_set, .nv_save, .cfg_prot_start, .cfg_prot_count, .cfg_locked, .cfg_he_block,
    .cfg_he_set, .busy);
  // ====================
  // Array stalls at random; storage keeps what the block saves
  always @(posedge mclk) begin
    arr_wr_ready <= ($random(seed) & 1) != 0;
    sv_r <= nv_save;
    bc <= busy ? bc + 1 : bc;
    if (arr_wr_valid && arr_wr_ready) wq.push_back({arr_wr_addr, arr_wr_data});
    if (sv_r) {nv_prot_start, nv_prot_count, nv_locked, nv_he_block, nv_he_set} <=
      {cfg_prot_start, cfg_prot_count, cfg_locked, cfg_he_block, cfg_he_set};
  end
  task automatic chk(input logic [20:0] s, input logic [20:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [20:0] cf();
    return 21'({cfg_prot_start, cfg_prot_count, cfg_locked, cfg_he_block, cfg_he_set});
  endfunction
  // Region is [start, start+count) with no wrap; count zero protects nothing
  function automatic logic prot(input logic [12:0] ad);
    return pcn != 4'h0 && ad[12:9] >= pst && {1'b0, ad[12:9]} < {1'b0, pst} + pcn;
  endfunction
  task automatic wb(input logic [7:0] v, input logic e);
    m.wbyte(v, a);
    chk(21'(a), 21'(e));
  endtask
  // Bounded wait for the write cycle to end
  task automatic idle();
    for (int c = 0; busy !== 1'b0; c++) begin
      if (c > 30000) begin
        fail_count++;
        conclude();
      end
      @(posedge mclk);
    end
  endtask
  task automatic cfg(input logic [7:0] hi, input logic [7:0] c, input logic s);
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    wb(hi, 1'b1);
    wb(8'($random(seed)), 1'b1);
    wb(c, 1'b1);
    if (s) begin
      m.stop();
      idle();
    end
  endtask
  // Load n random bytes from a0, poll, then compare what reached the array
  task automatic wr(input logic [12:0] a0, input integer n);
    logic [7:0]  cv [0:63];
    logic [63:0] ld;
    logic [12:0] ad;
    integer k, b0, pg;
    ld = 64'h0;
    pg = 0;
    m.start();
    wb({DEV, cs, 1'b0}, 1'b1);
    wb({3'h0, a0[12:8]}, 1'b1);
    wb(a0[7:0], 1'b1);
    for (k = 0; k < n; k++) begin
      d[k] = 8'($random(seed));
      wb(d[k], 1'b1);
      cv[(a0[2:0] + k) % 64] = d[k];
      ld[(a0[2:0] + k) % 64] = 1'b1;
    end
    b0 = bc;
    m.stop();
    m.start();
    wb({DEV, cs, 1'b0}, 1'b0);
    m.stop();
    idle();
    for (k = 0; k < 64; k++) begin
      ad = {a0[12:3] + 10'(k / 8), 3'(k)};
      if (ld[k] && !prot(ad)) eq.push_back({ad, cv[k]});
      if (k % 8 == 0 && ld[k +: 8] != 8'h0) pg++;
    end
    chk(21'(bc - b0 >= pg * PC && bc - b0 <= pg * (PC + 40)), 21'h1);
    chk(21'(wq.size()), 21'(eq.size()));
    foreach (eq[j]) chk(wq[j], eq[j]);
    wq.delete();
    eq.delete();
    $display("write test at %h done", a0);
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    cs <= 3'($random(seed));
    repeat (8) @(posedge mclk);
    chk(cf(), 21'({4'hf, 4'h0, 1'b0, 4'hf, 1'b0}));
    m.start();
    wb({~DEV, cs, 1'b0}, 1'b0);
    m.start();
    wb({DEV, ~cs, 1'b0}, 1'b0);
    m.stop();
    wr(13'h1ff6, 3);
    cfg(8'h86, 8'h00, 1'b1);
    chk(cf(), 21'({4'hf, 4'h0, 1'b0, 4'h3, 1'b1}));
    x = $random(seed);
    cfg({1'b1, x[6:5], 4'h5, x[0]}, {2'b10, x[5:4], 4'h3}, 1'b1);
    pst = 4'h5;
    pcn = 4'h3;
    chk(cf(), 21'({4'h5, 4'h3, 1'b1, 4'h3, 1'b1}));
    cfg(8'h8c, 8'h82, 1'b1);
    cfg(8'h8e, 8'h00, 1'b1);
    chk(cf(), 21'({4'h5, 4'h3, 1'b1, 4'h3, 1'b1}));
    cfg(8'h80, 8'hc0, 1'b0);
    m.start();
    wb({DEV, cs, 1'b1}, 1'b1);
    m.rbyte(b, 1'b1);
    chk(21'(b), 21'h0000f5);
    m.rbyte(b, 1'b0);
    chk(21'(b), 21'h0000f3);
    m.stop();
    $display("settings test done");
    wr(13'h09fc, 6);
    wr(13'h0101, 66);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(cf(), 21'({4'h5, 4'h3, 1'b1, 4'h3, 1'b1}));
    conclude();
  end
endmodule
`default_nettype wire
